// ===== dv/ouptim_src_model.sv
// Partner model: trigger and clock sources on the routing terminals
module ouptim_src_model (
   input  wire logic       i_clk,
   input  wire logic       i_hold,
   input  wire logic [3:0] i_burst,
   output logic [15:0]     o_pft,
   output logic [7:0]      o_sync,
   output logic [7:0]      o_bp,
   output logic            o_cmp,
   output logic            o_refclk
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] left = 4'h0;
   logic [2:0] ph = 3'h0;
   // Three-cycle pulses every six cycles, slow enough for the two-stage input sync
   always @(posedge i_clk) begin
      if (i_burst != 4'h0) begin
         left <= i_burst;
         ph   <= 3'h0;
      end else begin
         ph <= (ph == 3'h5) ? 3'h0 : ph + 3'h1;
         if (ph == 3'h5 && left != 4'h0) left <= left - 4'h1;
      end
   end
   // Terminal 3 carries the strobe, terminal 0 the hold level; the rest idle low
   assign o_pft    = {12'h000, left != 4'h0 && ph < 3'h3, 2'b00, i_hold};
   assign o_sync   = 8'h00;
   assign o_bp     = 8'h00;
   assign o_cmp    = 1'b0;
   assign o_refclk = 1'b0;
endmodule // ouptim_src_model

// ===== dv/ouptim_tb_top.sv
// Testbench: register table, finite, external and held runs of the timing engine
module ouptim_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import ouptim_pkg::*;
   typedef struct packed {logic [5:0] a; logic [31:0] v; logic [1:0] r;} ouptim_row_t;
   logic        i_clk = 1'b0, i_arst_n = 1'b0, i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
   logic        i_arvalid = 1'b0, i_rready = 1'b0, i_bp_refclk, i_cmp_event, hold = 1'b0, sd = 1'b0;
   logic [5:0]  i_awaddr = 6'h00, i_araddr = 6'h00, i_int_src = 6'h00;
   logic [31:0] i_wdata = 32'h0, o_rdata;
   logic [3:0]  i_wstrb = 4'hf, o_dac_load, burst = 4'h0;
   logic [2:0]  i_tb_tick = 3'h0;
   logic [15:0] i_pft, o_pft_o, o_pft_oe;
   logic [7:0]  i_sync_line, i_bp_trig, o_sync_o, o_sync_oe, o_bp_o, o_bp_oe;
   logic [1:0]  o_bresp, o_rresp;
   logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_update_strobe, o_running;
   int          fail_count = 0, n_checks = 0, n_load = 0, gap = 0, cyc = 0, last = 0, b;
   localparam ouptim_row_t ROWS [13] = '{'{A_CTRL, 32'h0, RESP_OKAY}, '{A_CMD, 32'h0, RESP_OKAY},
      '{A_BASE_SEL, 32'h0, RESP_OKAY}, '{A_STRB_SEL, 32'h3f, RESP_OKAY}, '{A_TRIG_SEL, 32'h3f, RESP_OKAY},
      '{A_HOLD_SEL, 32'h3f, RESP_OKAY}, '{A_DIVIDE, 32'h4, RESP_OKAY}, '{A_DELAY, 32'h2, RESP_OKAY},
      '{A_SAMPLES, 32'h4, RESP_OKAY}, '{A_ROUTE, 32'h0, RESP_OKAY}, '{A_STATUS, 32'h0, RESP_OKAY},
      '{A_COUNT, 32'h0, RESP_OKAY}, '{6'h30, 32'h0, RESP_SLVERR}};

   ouptim_top uut (.i_clk, .i_arst_n, .i_awvalid, .o_awready, .i_awaddr, .i_wvalid, .o_wready, .i_wdata,
      .i_wstrb, .o_bvalid, .i_bready, .o_bresp, .i_arvalid, .o_arready, .i_araddr, .o_rvalid, .i_rready,
      .o_rdata, .o_rresp, .i_tb_tick, .i_bp_refclk, .i_pft, .i_sync_line, .i_bp_trig, .i_cmp_event,
      .i_int_src, .o_dac_load, .o_update_strobe, .o_pft_o, .o_pft_oe, .o_sync_o, .o_sync_oe, .o_bp_o,
      .o_bp_oe, .o_running);
   ouptim_src_model src (.i_clk, .i_hold(hold), .i_burst(burst), .o_pft(i_pft), .o_sync(i_sync_line),
      .o_bp(i_bp_trig), .o_cmp(i_cmp_event), .o_refclk(i_bp_refclk));

   always #4 i_clk = ~i_clk;

   // ==========================================================
   // Bus and compare tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      logic aw, w;
      aw = 1'b1;
      w = 1'b1;
      @(posedge i_clk);
      i_awvalid <= 1'b1;
      i_wvalid <= 1'b1;
      i_awaddr <= a;
      i_wdata <= d;
      i_bready <= 1'b1;
      while (aw || w) begin
         @(posedge i_clk);
         if (o_awready === 1'b1) aw = 1'b0;
         if (o_wready === 1'b1) w = 1'b0;
         i_awvalid <= aw;
         i_wvalid <= w;
      end
      do @(posedge i_clk); while (o_bvalid !== 1'b1);
      i_bready <= 1'b0;
      chk({30'h0, o_bresp}, {30'h0, RESP_OKAY});
   endtask
   task automatic rd_chk(input logic [5:0] a, input logic [31:0] v, input logic [1:0] r);
      @(posedge i_clk);
      i_arvalid <= 1'b1;
      i_araddr <= a;
      i_rready <= 1'b1;
      do begin
         @(posedge i_clk);
         if (o_arready === 1'b1) i_arvalid <= 1'b0;
      end while (o_rvalid !== 1'b1);
      i_rready <= 1'b0;
      chk(o_rdata, v);
      chk({30'h0, o_rresp}, {30'h0, r});
   endtask
   task automatic stop_test;
      $display("checks=%0d mismatches=%0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // ==========================================================
   // Monitors: load pulses, strobe spacing, exported level
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      sd <= o_update_strobe;
      if (o_dac_load === 4'hf) n_load <= n_load + 1;
      if (o_update_strobe === 1'b1 && sd === 1'b0) begin
         gap <= cyc - last;
         last <= cyc;
      end
      if (cyc > 20) chk(o_pft_o, {16'h0, {16{~sd}}});
      if (cyc > 20) chk({o_sync_o, o_bp_o}, {16'h0, {16{~sd}}});
      if (cyc > 20) chk(o_dac_load, {4{o_dac_load[0]}});
   end
   initial begin
      repeat (5000) @(posedge i_clk);
      fail_count++;
      stop_test;
   end

   // ==========================================================
   // Main sequence
   initial begin
      repeat (8) @(posedge i_clk);
      i_arst_n <= 1'b1;
      repeat (3) @(posedge i_clk);
      chk({o_pft_oe, o_sync_oe, o_bp_oe}, 32'h0);
      chk({31'h0, o_running}, 32'h0);
      foreach (ROWS[i]) rd_chk(ROWS[i].a, ROWS[i].v, ROWS[i].r);
      $display("test register table done");
      i_tb_tick <= 3'h1;
      wr(A_ROUTE, 32'hffff_ffff);
      wr(A_CTRL, 32'h1);
      b = n_load;
      wr(A_CMD, 32'h1);
      wr(A_CMD, 32'h1);
      repeat (60) @(posedge i_clk);
      chk(n_load - b, 4);
      chk(gap, 4);
      chk({o_pft_oe, o_sync_oe, o_bp_oe}, 32'hffff_ffff);
      chk(o_running, 0);
      $display("test finite run done");
      wr(A_CTRL, 32'h0);
      wr(A_STRB_SEL, 32'h7);
      b = n_load;
      wr(A_CMD, 32'h1);
      wr(A_CMD, 32'h1);
      burst <= 4'h5;
      @(posedge i_clk);
      burst <= 4'h0;
      repeat (60) @(posedge i_clk);
      chk(n_load - b, 5);
      wr(A_CMD, 32'h2);
      repeat (4) @(posedge i_clk);
      chk(o_running, 0);
      $display("test external strobe done");
      wr(A_STRB_SEL, 32'h3f);
      wr(A_HOLD_SEL, 32'h4);
      hold <= 1'b1;
      b = n_load;
      wr(A_CMD, 32'h1);
      wr(A_CMD, 32'h1);
      repeat (40) @(posedge i_clk);
      chk(n_load - b, 0);
      hold <= 1'b0;
      repeat (12) @(posedge i_clk);
      chk(n_load - b > 0, 1);
      wr(A_CMD, 32'h2);
      $display("test hold done");
      wr(A_CTRL, 32'h7);
      b = n_load;
      wr(A_CMD, 32'h1);
      wr(A_CMD, 32'h1);
      repeat (30) @(posedge i_clk);
      wr(A_CMD, 32'h1);
      repeat (30) @(posedge i_clk);
      chk(n_load - b, 8);
      rd_chk(A_STATUS, 32'h11, RESP_OKAY);
      rd_chk(A_COUNT, 32'h4, RESP_OKAY);
      $display("test retrigger done");
      stop_test;
   end
endmodule // ouptim_tb_top

// ===== rtl/ouptim_div.sv
// Module: reloading base clock divider for the output update strobe
module ouptim_div #(
   parameter int CW = 32
) (
   input  wire logic i_clk,
   input  wire logic i_rst_n,
   ouptim_div_if.dv  d
);
   import ouptim_pkg::*;

   logic [CW-1:0] cnt;
   logic          last;

   // Zero divide behaves as one so the strobe never stalls
   assign last    = (cnt <= CW'(1));
   assign d.pulse = d.en & d.tick & last; // R17

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt <= '0;
      end else if (d.load) begin
         cnt <= d.div;
      end else if (d.en && d.tick) begin
         cnt <= last ? d.div : cnt - CW'(1); // R17
      end
   end
endmodule : ouptim_div

// ===== rtl/ouptim_div_if.sv
// Interface: control and pulse signals between the engine and its base clock divider
interface ouptim_div_if #(parameter int CW = 32);
   logic          load;
   logic          tick;
   logic          en;
   logic [CW-1:0] div;
   logic          pulse;

   modport ctl (output load, output tick, output en, output div, input pulse);
   modport dv  (input load, input tick, input en, input div, output pulse);
endinterface : ouptim_div_if

// ===== rtl/ouptim_pkg.sv
// Package: register map, field layout, reset values and source indices for the output update timing engine
//
// Behaviour
// R1: Each output update strobe pulse makes every analog output converter channel load its next value at once.
// R2: A configuration bit chooses whether converters update on the rising or the falling edge of the strobe.
// R3: With an internal strobe, a programmable counter divides the selected base clock to make the strobe.
// R4: The strobe source may be the divided base clock, a counter output, change detection or another strobe.
// R5: The strobe source may also be any of 16 function terminals, 8 sync lines, backplane triggers or comparator.
// R6: The strobe leaves the block on terminals, sync lines and backplane triggers as an active-low pulse.
// R7: The engine makes the strobe itself unless an external source is chosen, which then passes straight through.
// R8: The run trigger starts the engine, and after a finite run hardware or a software stop command ends it.
// R9: A programmable delay, two base clock periods by default, lies between run trigger and first strobe.
// R10: The base clock may be the 100 MHz, 20 MHz or 100 kHz timebase, backplane reference or external lines.
// R11: The base clock itself never leaves the block; only the strobe and triggers are exported.
// R12: An external clock can serve as the base clock to be divided or directly as the undivided strobe.
// R13: A retriggerable run trigger is ignored during a burst and re-arms once the burst is over.
// R14: An asserted hold trigger blocks strobes from the next sample onward but never cuts one in progress.
// R15: After hold ends, updates resume at once on the onboard clock, otherwise at the next source edge; a hold at the delay end resumes at once on any base clock.
// R16: In finite mode the engine stops making strobes once the programmed sample count is reached.
// R17: A divide value N gives one strobe per N selected base clock edges, reloading after each pulse.
package ouptim_pkg;

   // =====================================================================
   // Bus geometry and register offsets
   localparam int          AW          = 6;
   localparam int          DW          = 32;
   localparam logic [5:0]  A_CTRL      = 6'h00;
   localparam logic [5:0]  A_CMD       = 6'h04;
   localparam logic [5:0]  A_BASE_SEL  = 6'h08;
   localparam logic [5:0]  A_STRB_SEL  = 6'h0c;
   localparam logic [5:0]  A_TRIG_SEL  = 6'h10;
   localparam logic [5:0]  A_HOLD_SEL  = 6'h14;
   localparam logic [5:0]  A_DIVIDE    = 6'h18;
   localparam logic [5:0]  A_DELAY     = 6'h1c;
   localparam logic [5:0]  A_SAMPLES   = 6'h20;
   localparam logic [5:0]  A_ROUTE     = 6'h24;
   localparam logic [5:0]  A_STATUS    = 6'h28;
   localparam logic [5:0]  A_COUNT     = 6'h2c;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   // =====================================================================
   // Field positions
   localparam int CB_FINITE    = 0;
   localparam int CB_RETRIG    = 1;
   localparam int CB_UPD_FALL  = 2;
   localparam int CB_BASE_FALL = 3;
   localparam int CB_TRIG_FALL = 4;
   localparam int CB_HOLD_LOW  = 5;
   localparam int CMD_ARM      = 0;
   localparam int CMD_STOP     = 1;
   localparam int RT_PFT_LO    = 0;
   localparam int RT_SYNC_LO   = 16;
   localparam int RT_BP_LO     = 24;

   // =====================================================================
   // Reset values
   localparam logic [5:0]  CTRL_RST    = 6'h00;
   localparam logic [5:0]  SEL_NONE    = 6'h3f;
   localparam logic [5:0]  BASE_RST    = 6'h00;
   localparam logic [31:0] DIVIDE_RST  = 32'h0000_0004;
   localparam logic [31:0] DELAY_RST   = 32'h0000_0002;
   localparam logic [31:0] SAMPLES_RST = 32'h0000_0004;
   localparam logic [31:0] ROUTE_RST   = 32'h0000_0000;

   // =====================================================================
   // Source vector layout
   localparam int S_TB100  = 0;
   localparam int S_TB20   = 1;
   localparam int S_TB100K = 2;
   localparam int S_REFCLK = 3;
   localparam int S_PFT    = 4;
   localparam int S_SYNC   = 20;
   localparam int S_BP     = 28;
   localparam int S_CMP    = 36;
   localparam int S_INT    = 37;
   localparam int NPIN     = 34;
   localparam int NSRC     = 43;

   // =====================================================================
   // Timing
   localparam int          STRB_W      = 2;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_WAIT  = 2'b01,
      ST_DELAY = 2'b10,
      ST_RUN   = 2'b11
   } ouptim_state_t;

endpackage : ouptim_pkg

// ===== rtl/ouptim_top.sv
// Module: output update timing engine with AXI4-Lite register access
//
// Register access over AXI4-Lite and the register offsets were chosen for this implementation.
module ouptim_top #(
   parameter int CW   = 32,
   parameter int N_CH = 4
) (
   input  wire logic                   i_clk,
   input  wire logic                   i_arst_n,
   input  wire logic                   i_awvalid,
   output logic                        o_awready,
   input  wire logic [ouptim_pkg::AW-1:0] i_awaddr,
   input  wire logic                   i_wvalid,
   output logic                        o_wready,
   input  wire logic [ouptim_pkg::DW-1:0] i_wdata,
   input  wire logic [3:0]             i_wstrb,
   output logic                        o_bvalid,
   input  wire logic                   i_bready,
   output logic [1:0]                  o_bresp,
   input  wire logic                   i_arvalid,
   output logic                        o_arready,
   input  wire logic [ouptim_pkg::AW-1:0] i_araddr,
   output logic                        o_rvalid,
   input  wire logic                   i_rready,
   output logic [ouptim_pkg::DW-1:0]   o_rdata,
   output logic [1:0]                  o_rresp,
   input  wire logic [2:0]             i_tb_tick,
   input  wire logic                   i_bp_refclk,
   input  wire logic [15:0]            i_pft,
   input  wire logic [7:0]             i_sync_line,
   input  wire logic [7:0]             i_bp_trig,
   input  wire logic                   i_cmp_event,
   input  wire logic [5:0]             i_int_src,
   output logic [N_CH-1:0]             o_dac_load,
   output logic                        o_update_strobe,
   output logic [15:0]                 o_pft_o,
   output logic [15:0]                 o_pft_oe,
   output logic [7:0]                  o_sync_o,
   output logic [7:0]                  o_sync_oe,
   output logic [7:0]                  o_bp_o,
   output logic [7:0]                  o_bp_oe,
   output logic                        o_running
);
   import ouptim_pkg::*;

   // =====================================================================
   // Reset release and pin synchronisers
   logic                rst_meta;
   logic                rst_n;
   logic [NPIN-1:0]     pin_meta;
   logic [NPIN-1:0]     pin_sync;
   logic [NSRC-1:0]     lvl;
   logic [NSRC-1:0]     lvl_d;
   logic [NSRC-1:0]     rise;
   logic [NSRC-1:0]     fall;

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_meta <= '0;
         pin_sync <= '0;
         lvl_d    <= '0;
      end else begin
         pin_meta <= {i_cmp_event, i_bp_trig, i_sync_line, i_pft, i_bp_refclk}; // R5 R10
         pin_sync <= pin_meta;
         lvl_d    <= lvl;
      end
   end

   // Timebase ticks are same-domain enables, so they count as edges directly
   assign lvl = {i_int_src, pin_sync, i_tb_tick}; // R4 R5 R10

   genvar gi;
   generate
      for (gi = 0; gi < NSRC; gi++) begin : g_edge
         if (gi < S_REFCLK) begin : g_tick
            assign rise[gi] = lvl[gi];
            assign fall[gi] = lvl[gi];
         end else begin : g_det
            assign rise[gi] = lvl[gi] & ~lvl_d[gi];
            assign fall[gi] = ~lvl[gi] & lvl_d[gi];
         end
      end
   endgenerate

   function automatic logic pick(input logic [NSRC-1:0] v, input logic [5:0] sel);
      pick = (int'(sel) < NSRC) ? v[sel] : 1'b0;
   endfunction

   // =====================================================================
   // Registers
   logic [5:0]      ctrl;
   logic [5:0]      base_sel;
   logic [5:0]      strb_sel;
   logic [5:0]      trig_sel;
   logic [5:0]      hold_sel;
   logic [CW-1:0]   divide;
   logic [CW-1:0]   delay;
   logic [CW-1:0]   samples;
   logic [31:0]     route;
   logic            arm_p;
   logic            stop_p;
   logic            done;
   logic [CW-1:0]   scount;
   logic [AW-1:0]   awaddr;
   logic [DW-1:0]   wdata;
   logic [3:0]      wstrb;
   logic            wr_go;
   logic            wr_hit;
   ouptim_state_t   state;
   logic            pending;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
      merge = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) merge[8*b +: 8] = nw[8*b +: 8];
      end
   endfunction

   assign wr_go  = !o_awready && !o_wready && !o_bvalid;
   assign wr_hit = (awaddr <= A_ROUTE) && (awaddr[1:0] == 2'b00);

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_awready <= 1'b1;
         o_wready  <= 1'b1;
         o_bvalid  <= 1'b0;
         o_bresp   <= RESP_OKAY;
         awaddr    <= '0;
         wdata     <= '0;
         wstrb     <= '0;
      end else begin
         if (i_awvalid && o_awready) begin
            o_awready <= 1'b0;
            awaddr    <= i_awaddr;
         end
         if (i_wvalid && o_wready) begin
            o_wready <= 1'b0;
            wdata    <= i_wdata;
            wstrb    <= i_wstrb;
         end
         if (wr_go) begin
            o_awready <= 1'b1;
            o_wready  <= 1'b1;
            o_bvalid  <= 1'b1;
            o_bresp   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (o_bvalid && i_bready) begin
            o_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl     <= CTRL_RST;
         base_sel <= BASE_RST;
         strb_sel <= SEL_NONE;
         trig_sel <= SEL_NONE;
         hold_sel <= SEL_NONE;
         divide   <= CW'(DIVIDE_RST);
         delay    <= CW'(DELAY_RST); // R9
         samples  <= CW'(SAMPLES_RST);
         route    <= ROUTE_RST;
         arm_p    <= 1'b0;
         stop_p   <= 1'b0;
      end else begin
         arm_p  <= 1'b0;
         stop_p <= 1'b0;
         if (wr_go && wr_hit) begin
            case (awaddr)
               A_CTRL:     ctrl     <= 6'(merge(32'(ctrl), wdata, wstrb)); // R2
               A_CMD: begin
                  arm_p  <= wstrb[0] & wdata[CMD_ARM];
                  stop_p <= wstrb[0] & wdata[CMD_STOP]; // R8
               end
               A_BASE_SEL: base_sel <= 6'(merge(32'(base_sel), wdata, wstrb)); // R10 R12
               A_STRB_SEL: strb_sel <= 6'(merge(32'(strb_sel), wdata, wstrb)); // R4 R5 R12
               A_TRIG_SEL: trig_sel <= 6'(merge(32'(trig_sel), wdata, wstrb));
               A_HOLD_SEL: hold_sel <= 6'(merge(32'(hold_sel), wdata, wstrb));
               A_DIVIDE:   divide   <= CW'(merge(32'(divide), wdata, wstrb)); // R3
               A_DELAY:    delay    <= CW'(merge(32'(delay), wdata, wstrb)); // R9
               A_SAMPLES:  samples  <= CW'(merge(32'(samples), wdata, wstrb));
               A_ROUTE:    route    <= merge(route, wdata, wstrb);
               default: ;
            endcase
         end
      end
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_arready <= 1'b1;
         o_rvalid  <= 1'b0;
         o_rdata   <= '0;
         o_rresp   <= RESP_OKAY;
      end else if (i_arvalid && o_arready) begin
         o_arready <= 1'b0;
         o_rvalid  <= 1'b1;
         o_rresp   <= RESP_OKAY;
         case (i_araddr)
            A_CTRL:     o_rdata <= 32'(ctrl);
            A_CMD:      o_rdata <= '0;
            A_BASE_SEL: o_rdata <= 32'(base_sel);
            A_STRB_SEL: o_rdata <= 32'(strb_sel);
            A_TRIG_SEL: o_rdata <= 32'(trig_sel);
            A_HOLD_SEL: o_rdata <= 32'(hold_sel);
            A_DIVIDE:   o_rdata <= 32'(divide);
            A_DELAY:    o_rdata <= 32'(delay);
            A_SAMPLES:  o_rdata <= 32'(samples);
            A_ROUTE:    o_rdata <= route;
            A_STATUS:   o_rdata <= {27'h0, done, pending, o_running, state};
            A_COUNT:    o_rdata <= 32'(scount);
            default: begin
               o_rdata <= '0;
               o_rresp <= RESP_SLVERR;
            end
         endcase
      end else if (o_rvalid && i_rready) begin
         o_rvalid  <= 1'b0;
         o_arready <= 1'b1;
      end
   end

   // =====================================================================
   // Engine
   logic            base_tick;
   logic            internal;
   logic            onboard;
   logic            trig_ev;
   logic            hold_act;
   logic            src_ev;
   logic            emit;
   logic            last_smp;
   logic [CW-1:0]   dcnt;
   ouptim_div_if #(.CW(CW)) div_bus ();

   assign internal  = (strb_sel == SEL_NONE); // R7
   assign onboard   = internal && (int'(base_sel) < S_REFCLK);
   assign base_tick = ctrl[CB_BASE_FALL] ? pick(fall, base_sel) : pick(rise, base_sel); // R10 R12
   assign trig_ev   = (trig_sel == SEL_NONE) ? arm_p
                    : (ctrl[CB_TRIG_FALL] ? pick(fall, trig_sel) : pick(rise, trig_sel));
   assign hold_act  = (hold_sel != SEL_NONE) && (pick(lvl, hold_sel) ^ ctrl[CB_HOLD_LOW]);
   // External strobe passes undivided on its rising edge
   assign src_ev    = internal ? div_bus.pulse : pick(rise, strb_sel); // R7 R12

   always_comb begin
      emit = 1'b0;
      if (state == ST_DELAY && internal && base_tick && dcnt <= CW'(1) && !hold_act) begin
         emit = 1'b1; // R9
      end else if (state == ST_RUN && !hold_act) begin
         emit = src_ev | pending; // R14 R15
      end
   end

   assign last_smp = ctrl[CB_FINITE] && (scount + CW'(1) >= samples); // R16

   assign div_bus.load = (state != ST_RUN);
   assign div_bus.tick = base_tick;
   assign div_bus.en   = (state == ST_RUN) && internal; // R3
   assign div_bus.div  = divide;

   ouptim_div #(.CW(CW)) u_div (
      .i_clk   (i_clk),
      .i_rst_n (rst_n),
      .d       (div_bus)
   );

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         state   <= ST_IDLE;
         dcnt    <= '0;
         scount  <= '0;
         done    <= 1'b0;
         pending <= 1'b0;
      end else if (stop_p) begin
         state   <= ST_IDLE; // R8
         pending <= 1'b0;
      end else begin
         case (state)
            ST_IDLE: begin
               if (arm_p) begin
                  state <= ST_WAIT;
                  done  <= 1'b0;
               end
            end
            ST_WAIT: begin
               if (trig_ev || (arm_p && trig_sel == SEL_NONE)) begin
                  state  <= internal ? ST_DELAY : ST_RUN; // R8
                  dcnt   <= delay;
                  scount <= '0;
               end
            end
            ST_DELAY: begin
               // Run trigger ignored here and in ST_RUN until the burst ends
               if (base_tick && dcnt <= CW'(1)) begin
                  pending <= hold_act; // R14
                  if (emit) begin
                     scount <= scount + CW'(1);
                  end
                  state <= (emit && last_smp) ? (ctrl[CB_RETRIG] ? ST_WAIT : ST_IDLE) : ST_RUN;
                  done  <= emit && last_smp;
               end else if (base_tick) begin
                  dcnt <= dcnt - CW'(1); // R9
               end
            end
            ST_RUN: begin
               if (hold_act && src_ev && onboard) begin
                  pending <= 1'b1; // R15
               end else if (emit) begin
                  pending <= 1'b0;
               end
               if (emit) begin
                  scount <= scount + CW'(1);
                  if (last_smp) begin
                     state <= ctrl[CB_RETRIG] ? ST_WAIT : ST_IDLE; // R13 R16
                     done  <= 1'b1;
                  end
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // =====================================================================
   // Strobe shaping, converter load and export
   // Limitation: divides at or below STRB_W merge adjacent strobes into one
   logic [1:0] scnt;
   logic       strb_d;
   logic       upd;

   assign upd = ctrl[CB_UPD_FALL] ? (strb_d & ~o_update_strobe) : (o_update_strobe & ~strb_d); // R2

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         scnt            <= '0;
         o_update_strobe <= 1'b0;
         strb_d          <= 1'b0;
         o_dac_load      <= '0;
         o_running       <= 1'b0;
      end else begin
         if (emit) begin
            scnt            <= 2'(STRB_W - 1);
            o_update_strobe <= 1'b1;
         end else if (scnt != 2'h0) begin
            scnt <= scnt - 2'h1; // R14
         end else begin
            o_update_strobe <= 1'b0;
         end
         strb_d     <= o_update_strobe;
         o_dac_load <= {N_CH{upd}}; // R1
         o_running  <= (state == ST_DELAY) || (state == ST_RUN);
      end
   end

   // Only the shaped strobe is exported; the base clock has no path out
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_pft_o   <= '1;
         o_pft_oe  <= '0;
         o_sync_o  <= '1;
         o_sync_oe <= '0;
         o_bp_o    <= '1;
         o_bp_oe   <= '0;
      end else begin
         o_pft_o   <= {16{~o_update_strobe}}; // R6 R11
         o_sync_o  <= {8{~o_update_strobe}}; // R6
         o_bp_o    <= {8{~o_update_strobe}}; // R6
         o_pft_oe  <= route[RT_PFT_LO +: 16];
         o_sync_oe <= route[RT_SYNC_LO +: 8];
         o_bp_oe   <= route[RT_BP_LO +: 8];
      end
   end

   // =====================================================================
   // Assertions
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!rst_n);

   sequence strb_up_s;
      $rose(o_update_strobe) && !ctrl[CB_UPD_FALL];
   endsequence
   sequence load_all_s;
      (o_dac_load == {N_CH{1'b1}});
   endsequence

   dac_all_a: assert property ((o_dac_load == '0) || (o_dac_load == {N_CH{1'b1}})) // R1
      else $error("converter channels loaded apart");
   upd_edge_a: assert property (strb_up_s |=> load_all_s) // R2
      else $error("rising strobe edge did not load converters");
   export_low_a: assert property (o_update_strobe |=> (o_pft_o == 16'h0000) && (o_sync_o == 8'h00)) // R6
      else $error("exported strobe not active low");
   pass_thru_a: assert property (state == ST_RUN && !internal && src_ev && !hold_act |=> o_update_strobe) // R7
      else $error("external strobe edge not passed");
   stop_cmd_a: assert property (stop_p |=> state == ST_IDLE) // R8
      else $error("stop command ignored");
   first_delay_a: assert property (state == ST_DELAY && internal && base_tick && dcnt <= CW'(1) && !hold_act
                                   |-> emit ##1 o_update_strobe) // R9
      else $error("first strobe missing after delay");
   retrig_ign_a: assert property (state == ST_RUN |=> state != ST_DELAY) // R13
      else $error("run trigger taken during burst");
   hold_block_a: assert property (hold_act |=> !$rose(o_update_strobe)) // R14
      else $error("strobe emitted while held");
   resume_a: assert property (state == ST_RUN && pending && !hold_act && !stop_p |=> o_update_strobe) // R15
      else $error("onboard resume not immediate");
   finite_end_a: assert property (emit && last_smp && !stop_p |=> state != ST_RUN) // R16
      else $error("finite run kept going");
endmodule : ouptim_top
